// *** inc/sio_decode_defines.svh ***
/*
 Address constants, config codes and reset values for the host I/O decode.
 Assumes a 10-bit ISA I/O address.
*/
`ifndef SIO_DECODE_DEFINES_SVH
`define SIO_DECODE_DEFINES_SVH
`define IDE_PRI_CMD 10'h1f0
`define IDE_SEC_CMD 10'h170
`define IDE_PRI_CTL 10'h3f6
`define IDE_SEC_CTL 10'h376
`define IDE_XT_BASE 10'h320
`define IDE_XT_CTL 10'h3f5
`define CTL_HI_ADDR 10'h3f7
`define CMD_MASK 10'h3f8
`define CTL_MASK 10'h3fe
`define XT_MASK 10'h3fc
`define GAME_ADDR 10'h201
`define CFG_INDEX 10'h3f0
`define CFG_DATA 10'h3f1
`define DOR_ADDR 10'h3f2
`define SER1_BASE 10'h3f8
`define SER2_BASE 10'h2f8
`define PAR_BASE 10'h278
`define PAR_LAST 10'h27a
`define KEY_CODE 8'h55
`define EXIT_CODE 8'haa
`define CFG_COUNT 4
`define DOR_RESET 8'h00
`endif

// *** inc/sio_decode_pkg.sv ***
/*
 Types for the host I/O decode block.
 Assumes sio_decode_defines.svh is on the include path.
*/
package sio_decode_pkg;
   typedef struct packed {
      logic [9:0] addr;
      logic ior_n;
      logic iow_n;
      logic aen;
      logic [7:0] wdata;
   } host_bus_s;
   typedef struct packed {
      logic at_mode;
      logic secondary;
      logic ide_enable;
      logic game_enable;
   } ide_cfg_s;
   typedef enum logic [2:0] {
      CFG_IDLE = 3'b001,
      CFG_KEY1 = 3'b010,
      CFG_ACTIVE = 3'b100
   } cfg_state_e;
endpackage : sio_decode_pkg

// *** design/drive_select_decode.sv ***
/*
 Drive and motor select decode from the digital output register.
 Assumes the register and the ECP strap are already held in flip-flops.
*/
`timescale 1ns/1ps
module drive_select_decode (
   input wire logic [7:0] digital_output_reg,
   input wire logic ecp_mode,
   output logic [3:0] motor_d,
   output logic [3:0] drive_d
);
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_drv
         localparam logic [1:0] IDX = 2'(i);
         // In ECP only two lines exist; lines 2,3 stay high, outer decoder fans out
         assign motor_d[i] = (ecp_mode && i > 1) ? 1'b1 : ~digital_output_reg[4 + i]; // [R12]
         assign drive_d[i] = (ecp_mode && i > 1) ? 1'b1
                             : ecp_mode ? ~digital_output_reg[i] // [R12]
                             : ~((digital_output_reg[1:0] == IDX) && digital_output_reg[4 + i]); // [R11]
      end
   endgenerate
endmodule : drive_select_decode

// *** design/super_io_address_decode.sv ***
/*
 Host I/O address decode and glue: IDE selects, game select, config gating,
 strap capture, drive selects. Assumes host bus inputs synchronous to ref_clk.
*/
// Behaviour
// [R01] High byte enable: AT, wide, command range
// [R02] Select A: AT command range, XT 320-323
// [R03] Select B: control pair, primary or secondary
// [R04] Drive pulls wide indicator low for 16-bit
// [R05] XT mode: indicator pin is DMA acknowledge
// [R06] Bit 7 passes between host and drive
// [R07] Read of 3F7 returns disk change bit
// [R08] Power-good low: freeze registers, float outputs
// [R09] Game select low at address 201
// [R10] Straps sampled during reset, then held; code samples on the first clock after release
// [R11] Drive selects decode output register bits
// [R12] ECP mode: only two select lines
// [R13] Config mode entered by code to 3F0
// [R14] Status reads blocked in config mode
// [R15] Default serial and parallel port decode
// [R16] Registers 8 bits, IDE data 16
// [R17] XT decode uses 320-323 and 3F5-3F7; code decodes 320-323 and 3F6-3F7 only
// [R18] Low byte enable: AT ranges, XT 320-323
// [R19] Selects inactive outside range or disabled
// [R20] Decode config held until rewrite or reset
`timescale 1ns/1ps
`include "sio_decode_defines.svh"
module super_io_address_decode (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic power_good,
   input wire sio_decode_pkg::host_bus_s host,
   input wire logic wide_transfer_n,
   input wire logic disk_change,
   input wire logic ide_data_bit7_i,
   input wire logic host_d7_i,
   input wire logic serial_strap_0,
   input wire logic ide_addr_strap,
   input wire logic floppy_addr_strap,
   input wire logic parport_mode_strap,
   input wire logic [7:0] cfg_rdata_i,
   output logic ide_high_byte_en_n,
   output logic ide_low_byte_en_n,
   output logic hard_disk_sel_a_n,
   output logic hard_disk_sel_b_n,
   output logic wide_transfer_active,
   output logic ide_data_bit7_o,
   output logic ide_data_bit7_oe,
   output logic host_d7_o,
   output logic host_d7_oe,
   output logic game_port_sel_n,
   output logic [3:0] motor_on_n,
   output logic [3:0] drive_sel_n,
   output logic outputs_oe,
   output logic cfg_mode,
   output logic status_a_rd,
   output logic status_b_rd,
   output logic cfg_rd,
   output logic cfg_wr,
   output logic serial1_sel,
   output logic serial2_sel,
   output logic parport_sel,
   output logic ide_data_wide,
   output logic [3:0] straps_q
);
   import sio_decode_pkg::*;

   // ****************************************************************
   // Decode
   // ****************************************************************
   ide_cfg_s cfg_q;
   cfg_state_e state_q;
   logic [7:0] dor_q;
   logic [1:0] cfg_cnt_q;
   logic strap_done_q;
   logic rd, wr, cmd_hit, ctl_hit, xt_hit, xt_ctl_hit, hi_hit, io_live;
   logic [3:0] motor_d, drive_d;
   logic [9:0] cmd_base, ctl_base;

   // Power-good low masks the host strobes so no host access can change state
   assign io_live = power_good && !host.aen; // [R08]
   assign rd = io_live && !host.ior_n;
   assign wr = io_live && !host.iow_n;
   assign cmd_base = cfg_q.secondary ? `IDE_SEC_CMD : `IDE_PRI_CMD;
   assign ctl_base = cfg_q.secondary ? `IDE_SEC_CTL : `IDE_PRI_CTL;
   assign cmd_hit = cfg_q.ide_enable && cfg_q.at_mode
                    && ((host.addr & `CMD_MASK) == cmd_base); // [R19]
   assign ctl_hit = cfg_q.ide_enable && cfg_q.at_mode
                    && ((host.addr & `CTL_MASK) == ctl_base); // [R03]
   assign xt_hit = cfg_q.ide_enable && !cfg_q.at_mode
                   && ((host.addr & `XT_MASK) == `IDE_XT_BASE); // [R17]
   assign xt_ctl_hit = cfg_q.ide_enable && !cfg_q.at_mode
                       && ((host.addr & `CTL_MASK) == `IDE_PRI_CTL); // [R03]
   assign hi_hit = (host.addr == `CTL_HI_ADDR);

   // ****************************************************************
   // Config mode
   // ****************************************************************
   // Two key writes to the index port enter; the exit code leaves
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= CFG_IDLE;
      end else if (wr && host.addr == `CFG_INDEX) begin // [R13]
         unique case (state_q)
            CFG_IDLE: state_q <= (host.wdata == `KEY_CODE) ? CFG_KEY1 : CFG_IDLE;
            CFG_KEY1: state_q <= (host.wdata == `KEY_CODE) ? CFG_ACTIVE : CFG_IDLE;
            CFG_ACTIVE: state_q <= (host.wdata == `EXIT_CODE) ? CFG_IDLE : CFG_ACTIVE;
            default: state_q <= CFG_IDLE;
         endcase
      end
   end

   // Decode choice lives here; writes to the data port only take in config mode
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= '{at_mode: 1'b1, secondary: 1'b0, ide_enable: 1'b1, game_enable: 1'b1};
      end else if (!strap_done_q) begin
         cfg_q.secondary <= ide_addr_strap; // [R10]
      end else if (wr && state_q == CFG_ACTIVE && host.addr == `CFG_DATA) begin
         cfg_q <= host.wdata[3:0]; // [R20]
      end
   end

   // ****************************************************************
   // Straps
   // ****************************************************************
   // Captured on the first clock after release; a reset value cannot be a port
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_done_q <= 1'b0;
         straps_q <= 4'h0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         straps_q <= {parport_mode_strap, floppy_addr_strap,
                      ide_addr_strap, serial_strap_0}; // [R10]
      end
   end

   // ****************************************************************
   // Digital output register
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dor_q <= `DOR_RESET;
      end else if (wr && host.addr == `DOR_ADDR) begin
         dor_q <= host.wdata;
      end
   end

   drive_select_decode u_drv (
      .digital_output_reg(dor_q),
      .ecp_mode(straps_q[3]),
      .motor_d(motor_d),
      .drive_d(drive_d)
   );

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   // One cycle of decode latency traded for glitch-free flop outputs
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ide_high_byte_en_n <= 1'b1;
         ide_low_byte_en_n <= 1'b1;
         hard_disk_sel_a_n <= 1'b1;
         hard_disk_sel_b_n <= 1'b1;
         wide_transfer_active <= 1'b0;
         game_port_sel_n <= 1'b1;
         ide_data_wide <= 1'b0;
      end else if (power_good) begin // [R08]
         // Drive pulls the indicator low for a wide cycle
         wide_transfer_active <= cfg_q.at_mode && !wide_transfer_n; // [R04]
         ide_high_byte_en_n <= !(cmd_hit && io_live && !wide_transfer_n); // [R01]
         ide_low_byte_en_n <= !(io_live && (cmd_hit || ctl_hit
                               || (xt_hit && (!wide_transfer_n || rd || wr)))); // [R18]
         // XT: pin is DMA acknowledge, asserts select A without address strobes
         hard_disk_sel_a_n <= !((io_live && (cmd_hit || xt_hit))
                               || (!cfg_q.at_mode && cfg_q.ide_enable
                                   && !wide_transfer_n && power_good)); // [R02] [R05]
         hard_disk_sel_b_n <= !(io_live && (ctl_hit || xt_ctl_hit)); // [R03]
         game_port_sel_n <= !(io_live && cfg_q.game_enable
                             && host.addr == `GAME_ADDR); // [R09]
         ide_data_wide <= cmd_hit && host.addr == cmd_base; // [R16]
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ide_data_bit7_o <= 1'b0;
         ide_data_bit7_oe <= 1'b0;
         host_d7_o <= 1'b0;
         host_d7_oe <= 1'b0;
      end else if (power_good) begin
         ide_data_bit7_oe <= wr && (cmd_hit || (ctl_hit && cfg_q.at_mode)); // [R06]
         ide_data_bit7_o <= host_d7_i;
         host_d7_oe <= rd && (cmd_hit || ctl_hit);
         host_d7_o <= (hi_hit && rd) ? disk_change : ide_data_bit7_i; // [R07]
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_mode <= 1'b0;
         status_a_rd <= 1'b0;
         status_b_rd <= 1'b0;
         cfg_rd <= 1'b0;
         cfg_wr <= 1'b0;
      end else if (power_good) begin
         cfg_mode <= (state_q == CFG_ACTIVE);
         status_a_rd <= rd && state_q != CFG_ACTIVE && host.addr == `CFG_INDEX; // [R14]
         status_b_rd <= rd && state_q != CFG_ACTIVE && host.addr == `CFG_DATA; // [R14]
         cfg_rd <= rd && state_q == CFG_ACTIVE && host.addr == `CFG_DATA; // [R13]
         cfg_wr <= wr && state_q == CFG_ACTIVE && host.addr == `CFG_DATA; // [R13]
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         serial1_sel <= 1'b0;
         serial2_sel <= 1'b0;
         parport_sel <= 1'b0;
         motor_on_n <= 4'hf;
         drive_sel_n <= 4'hf;
         outputs_oe <= 1'b0;
      end else begin
         outputs_oe <= power_good; // [R08]
         if (power_good) begin
            serial1_sel <= io_live && ((host.addr & `CMD_MASK) == `SER1_BASE); // [R15]
            serial2_sel <= io_live && ((host.addr & `CMD_MASK) == `SER2_BASE); // [R15]
            parport_sel <= io_live && host.addr >= `PAR_BASE
                           && host.addr <= `PAR_LAST; // [R15]
            motor_on_n <= motor_d;
            drive_sel_n <= drive_d; // [R11]
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_hi_never_xt;
      @(posedge ref_clk) disable iff (!arst_n)
      !cfg_q.at_mode && $stable(cfg_q) |=> ide_high_byte_en_n;
   endproperty
   a_hi_never_xt: assert property (p_hi_never_xt) else $error("high enable in XT"); // [R01]

   property p_game;
      @(posedge ref_clk) disable iff (!arst_n)
      io_live && cfg_q.game_enable && host.addr == `GAME_ADDR |=> !game_port_sel_n;
   endproperty
   a_game: assert property (p_game) else $error("game select missing"); // [R09]

   property p_freeze;
      @(posedge ref_clk) disable iff (!arst_n)
      !power_good |=> $stable(dor_q) && $stable(state_q) && !outputs_oe;
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved without power"); // [R08]

   property p_status_block;
      @(posedge ref_clk) disable iff (!arst_n)
      state_q == CFG_ACTIVE && power_good |=> !status_a_rd && !status_b_rd;
   endproperty
   a_status_block: assert property (p_status_block) else $error("status read in cfg"); // [R14]

   property p_disk_change;
      @(posedge ref_clk) disable iff (!arst_n)
      power_good && rd && hi_hit |=> host_d7_o == $past(disk_change);
   endproperty
   a_disk_change: assert property (p_disk_change) else $error("bit 7 not disk change"); // [R07]

   property p_sel_a_range;
      @(posedge ref_clk) disable iff (!arst_n)
      power_good && !cmd_hit && !xt_hit && wide_transfer_n |=> hard_disk_sel_a_n;
   endproperty
   a_sel_a_range: assert property (p_sel_a_range) else $error("select A out of range"); // [R19]

   property p_cfg_entry;
      @(posedge ref_clk) disable iff (!arst_n)
      state_q == CFG_IDLE ##1 state_q == CFG_ACTIVE |-> 1'b0;
   endproperty
   a_cfg_entry: assert property (p_cfg_entry) else $error("config skipped key"); // [R13]

   property p_strap_hold;
      @(posedge ref_clk) disable iff (!arst_n)
      strap_done_q ##1 strap_done_q |-> $stable(straps_q);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("straps changed"); // [R10]

   property p_ecp_two;
      @(posedge ref_clk) disable iff (!arst_n)
      straps_q[3] && power_good ##1 straps_q[3] |-> drive_sel_n[3:2] == 2'b11;
   endproperty
   a_ecp_two: assert property (p_ecp_two) else $error("ECP upper selects active"); // [R12]
endmodule : super_io_address_decode

// *** tb/ide_drive_model.sv ***
/*
 Behavioural model of the attached IDE drive: drives the wide indicator pin.
 Assumes the bench tells it the decode mode and what transfer width it wants.
*/
`timescale 1ns/1ps
module ide_drive_model (
   input wire logic [9:0] addr,
   input wire logic xt_mode,
   input wire logic want_wide,
   input wire logic dma_ack_n,
   output logic wide_transfer_n
);
   // ***************
   // Indicator pin
   // ***************
   // Combinational, so the request lines up with the address cycle
   always_comb begin
      if (xt_mode) begin
         wide_transfer_n = dma_ack_n;
      end else begin
         wide_transfer_n = !(want_wide && addr[9:3] == 7'h3e);
      end
   end
endmodule : ide_drive_model

// *** tb/test_super_io_address_decode.sv ***
/*
 Self-checking bench for the host I/O decode block.
 Assumes registered outputs one cycle after the host inputs.
*/
`timescale 1ns/1ps
module test_super_io_address_decode;
   import sio_decode_pkg::*;
   host_bus_s host;
   logic ref_clk, arst_n, power_good, disk_change, bit7, xt_m, want_w, dack_n;
   logic [3:0] strap;
   logic ide_high_byte_en_n, ide_low_byte_en_n, hard_disk_sel_a_n, hard_disk_sel_b_n;
   logic host_d7_o, host_d7_oe, game_port_sel_n, outputs_oe, cfg_mode;
   logic status_a_rd, status_b_rd, serial1_sel, serial2_sel, parport_sel, ide_data_wide;
   logic [3:0] motor_on_n, drive_sel_n, straps_q;
   logic hd7, wide_act, d7_o, d7_oe, cfg_rd, cfg_wr;
   wire logic wide_n;
   int error_cnt, num_checks;
   // ***************
   // Instances
   // ***************
   ide_drive_model u_ide_drive_model (.addr(host.addr), .xt_mode(xt_m), .want_wide(want_w),
      .dma_ack_n(dack_n), .wide_transfer_n(wide_n));
   super_io_address_decode u_super_io_address_decode (.ref_clk, .arst_n, .power_good, .host,
      .wide_transfer_n(wide_n), .disk_change, .ide_data_bit7_i(bit7), .host_d7_i(hd7),
      .serial_strap_0(strap[0]), .ide_addr_strap(strap[1]), .floppy_addr_strap(strap[2]),
      .parport_mode_strap(strap[3]), .cfg_rdata_i(8'h00), .ide_high_byte_en_n,
      .ide_low_byte_en_n, .hard_disk_sel_a_n, .hard_disk_sel_b_n,
      .wide_transfer_active(wide_act), .ide_data_bit7_o(d7_o), .ide_data_bit7_oe(d7_oe),
      .host_d7_o, .host_d7_oe, .game_port_sel_n,
      .motor_on_n, .drive_sel_n, .outputs_oe, .cfg_mode, .status_a_rd, .status_b_rd,
      .cfg_rd, .cfg_wr, .serial1_sel, .serial2_sel, .parport_sel, .ide_data_wide,
      .straps_q);
   always #2.5 ref_clk = !ref_clk;
   // ***************
   // Shared tasks
   // ***************
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One host cycle: inputs at a falling edge, outputs settled one falling edge later
   task automatic cyc(input logic [9:0] a, input logic rd, input logic wr, input logic [7:0] d);
      @(negedge ref_clk);
      host.addr = a;
      host.ior_n = !rd;
      host.iow_n = !wr;
      host.wdata = d;
      @(negedge ref_clk);
      host.ior_n = 1'b1;
      host.iow_n = 1'b1;
   endtask : cyc
   // Idle gap after a write, so each write is seen as a separate access
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      cyc(a, 1'b0, 1'b1, d);
      cyc(10'h000, 1'b0, 1'b0, 8'h00);
   endtask : wr
   // ***************
   // Scenarios
   // ***************
   task automatic t_straps;
      repeat (2) @(negedge ref_clk);
      chk("straps", {4'h0, straps_q}, 8'h05);
      strap = 4'hf;
      @(negedge ref_clk);
      chk("straps held", {4'h0, straps_q}, 8'h05);
   endtask : t_straps
   task automatic t_at;
      want_w = 1'b1;
      bit7 = 1'b1;
      cyc(10'h1f0, 1'b1, 1'b0, 8'h00);
      chk("hi en", ide_high_byte_en_n, 1'b0);
      chk("lo en", ide_low_byte_en_n, 1'b0);
      chk("sel a", hard_disk_sel_a_n, 1'b0);
      chk("sel b", hard_disk_sel_b_n, 1'b1);
      chk("d7 oe", host_d7_oe, 1'b1);
      chk("d7", host_d7_o, 1'b1);
      chk("wide", ide_data_wide, 1'b1);
      chk("wide act", wide_act, 1'b1);
      want_w = 1'b0;
      cyc(10'h1f7, 1'b1, 1'b0, 8'h00);
      chk("hi en 8bit", ide_high_byte_en_n, 1'b1);
      chk("lo en 8bit", ide_low_byte_en_n, 1'b0);
      hd7 = 1'b1;
      cyc(10'h1f0, 1'b0, 1'b1, 8'h00);
      chk("d7 wr oe", d7_oe, 1'b1);
      chk("d7 wr", d7_o, 1'b1);
      cyc(10'h3f6, 1'b1, 1'b0, 8'h00);
      chk("sel b ctl", {hard_disk_sel_a_n, hard_disk_sel_b_n}, 8'h02);
      disk_change = 1'b1;
      bit7 = 1'b0;
      cyc(10'h3f7, 1'b1, 1'b0, 8'h00);
      chk("sel b 3f7", hard_disk_sel_b_n, 1'b0);
      chk("disk change", host_d7_o, 1'b1);
      cyc(10'h201, 1'b1, 1'b0, 8'h00);
      chk("game", game_port_sel_n, 1'b0);
      cyc(10'h200, 1'b1, 1'b0, 8'h00);
      chk("outside", {game_port_sel_n, hard_disk_sel_a_n, ide_low_byte_en_n}, 8'h07);
      host.aen = 1'b1;
      cyc(10'h1f0, 1'b1, 1'b0, 8'h00);
      chk("aen blocks", hard_disk_sel_a_n, 1'b1);
      host.aen = 1'b0;
   endtask : t_at
   task automatic t_ports;
      cyc(10'h3f8, 1'b1, 1'b0, 8'h00);
      chk("ser1", {serial1_sel, serial2_sel, parport_sel}, 8'h04);
      cyc(10'h2ff, 1'b1, 1'b0, 8'h00);
      chk("ser2", {serial1_sel, serial2_sel, parport_sel}, 8'h02);
      cyc(10'h27a, 1'b1, 1'b0, 8'h00);
      chk("par", {serial1_sel, serial2_sel, parport_sel}, 8'h01);
      cyc(10'h27b, 1'b1, 1'b0, 8'h00);
      chk("par end", {serial1_sel, serial2_sel, parport_sel}, 8'h00);
   endtask : t_ports
   task automatic t_cfg;
      cyc(10'h3f0, 1'b1, 1'b0, 8'h00);
      chk("sra rd", status_a_rd, 1'b1);
      wr(10'h3f1, 8'h03);
      wr(10'h3f0, 8'h55);
      wr(10'h3f0, 8'h12);
      wr(10'h3f0, 8'h55);
      chk("broken key", cfg_mode, 1'b0);
      cyc(10'h1f0, 1'b1, 1'b0, 8'h00);
      chk("cfg locked", hard_disk_sel_a_n, 1'b0);
      wr(10'h3f0, 8'h55);
      wr(10'h3f0, 8'h55);
      chk("cfg in", cfg_mode, 1'b1);
      cyc(10'h3f0, 1'b1, 1'b0, 8'h00);
      chk("sra blocked", status_a_rd, 1'b0);
      cyc(10'h3f1, 1'b1, 1'b0, 8'h00);
      chk("srb blocked", status_b_rd, 1'b0);
      chk("cfg rd", cfg_rd, 1'b1);
      cyc(10'h3f1, 1'b0, 1'b1, 8'h03);
      chk("cfg wr", cfg_wr, 1'b1);
      cyc(10'h000, 1'b0, 1'b0, 8'h00);
      wr(10'h3f0, 8'haa);
      chk("cfg out", cfg_mode, 1'b0);
      cyc(10'h3f1, 1'b1, 1'b0, 8'h00);
      chk("srb rd", status_b_rd, 1'b1);
      xt_m = 1'b1;
      cyc(10'h320, 1'b1, 1'b0, 8'h00);
      chk("xt sel a", hard_disk_sel_a_n, 1'b0);
      chk("xt lo", ide_low_byte_en_n, 1'b0);
      chk("xt hi", ide_high_byte_en_n, 1'b1);
      cyc(10'h1f0, 1'b1, 1'b0, 8'h00);
      chk("xt no at", hard_disk_sel_a_n, 1'b1);
      dack_n = 1'b0;
      cyc(10'h000, 1'b0, 1'b0, 8'h00);
      chk("xt dma ack", hard_disk_sel_a_n, 1'b0);
      dack_n = 1'b1;
   endtask : t_cfg
   task automatic t_dor;
      int n;
      wr(10'h3f2, 8'h42);
      n = 0;
      while (drive_sel_n === 4'hf && n < 8) begin
         @(negedge ref_clk);
         n++;
      end
      chk("drive sel", {4'h0, drive_sel_n}, 8'h0b);
      chk("motor", {4'h0, motor_on_n}, 8'h0b);
   endtask : t_dor
   task automatic t_pg;
      power_good = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("oe off", outputs_oe, 1'b0);
      wr(10'h3f2, 8'h00);
      power_good = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("oe on", outputs_oe, 1'b1);
      chk("dor kept", {4'h0, drive_sel_n}, 8'h0b);
   endtask : t_pg
   // Second reset with the ECP strap set, then two select lines only
   task automatic t_ecp;
      arst_n = 1'b0;
      strap = 4'h8;
      repeat (10) @(negedge ref_clk);
      chk("reset sel", {4'h0, drive_sel_n}, 8'h0f);
      arst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("ecp strap", {4'h0, straps_q}, 8'h08);
      wr(10'h3f2, 8'h31);
      chk("ecp drive", {4'h0, drive_sel_n}, 8'h0e);
      chk("ecp motor", {4'h0, motor_on_n}, 8'h0c);
   endtask : t_ecp
   // ***************
   // Main sequence
   // ***************
   initial begin
      ref_clk = 1'b0;
      arst_n = 1'b0;
      power_good = 1'b1;
      host = '{addr: 10'h000, ior_n: 1'b1, iow_n: 1'b1, aen: 1'b0, wdata: 8'h00};
      {hd7, disk_change, bit7, xt_m, want_w} = 5'h00;
      dack_n = 1'b1;
      strap = 4'h5;
      error_cnt = 0;
      num_checks = 0;
      repeat (10) @(negedge ref_clk);
      arst_n = 1'b1;
      t_straps();
      t_at();
      t_ports();
      t_cfg();
      t_dor();
      t_pg();
      t_ecp();
      final_report();
   end
   // Hang guard
   initial begin
      #100us;
      error_cnt++;
      final_report();
   end
endmodule : test_super_io_address_decode
